// ===== hw/hpbi_defs.vh
`ifndef HPBI_DEFS_VH
`define HPBI_DEFS_VH

// Synchroniser width: 7 strobes, 16 AD pins, 5 index pins, 15 straps.
`define HPBI_SYNC_W    43
`define HPBI_STRB_LSB  0
`define HPBI_AD_LSB    7
`define HPBI_IX_LSB    23
`define HPBI_CFG_LSB   28
`define HPBI_CFG_W     15

// Strap field positions inside the sampled configuration word.
`define HPBI_C_MUX     0
`define HPBI_C_DMAP    1
`define HPBI_C_W16     2
`define HPBI_C_DUAL    3
`define HPBI_C_STYLE   4
`define HPBI_C_QUAL    5
`define HPBI_C_CSPOL   6
`define HPBI_C_RDPOL   7
`define HPBI_C_WRPOL   8
`define HPBI_C_LNPOL   9
`define HPBI_C_LEPOL   10
`define HPBI_C_WTPOL   11
`define HPBI_C_WTOD    12
`define HPBI_C_WTEN    13
`define HPBI_C_BIGE    14

// Address widths in bits and the start of the system register space.
`define HPBI_LEG_ABITS 4'd10
`define HPBI_DM_ABITS  4'd14
`define HPBI_SYS_BASE  16'h3000
// Dword index of the bypass FIFO data word in indexed mode.
`define HPBI_IDX_FIFO  3'h6

// Cycles that the straps settle in the synchroniser before capture.
`define HPBI_CFG_WAIT  2'h3

`define HPBI_RST_WORD  32'h00000000
`define HPBI_RST_HALF  16'h0000

`endif

// ===== hw/hpbi_sync.v
`timescale 1ns/1ps
`default_nettype none

module hpbi_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire         ce,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta[g] <= 1'b0;
                    q[g]    <= 1'b0;
                end else if (ce) begin
                    meta[g] <= d[g];
                    q[g]    <= meta[g];
                end
            end
        end
    endgenerate

endmodule // hpbi_sync

`default_nettype wire

// ===== hw/hpbi_host_port.v
// Function
// R1: Mux or indexed addressing, width by strap.
// R2: Legacy mode assembles bytes/words into dwords.
// R3: Direct core space uses lanes, no assembly.
// R4: Separate strobes or cycle strobe plus direction.
// R5: Every control pin has selectable polarity; in open drain the wait pin ignores it.
// R6: Optional chip select qualification of latching.
// R7: Host waits for earlier internal access.
// R8: Wait pin shows data ready, write allowed.
// R9: Wait stays acknowledge outside direct mode.
// R10: Wait pin open drain or push-pull.
// R11: Wait pin disabled until strapped on.
// R12: Lane selects choose bytes in 16-bit; the code uses them only in direct core space.
// R13: Address and selects share data pins.
// R14: Single phase latches all 16 pins.
// R15: Upper pins never driven in 8-bit.
// R16: Latched address kept until next latch.
// R17: FIFO select routes accesses to FIFOs.
// R18: Endianness select swaps byte order.
// R19: Dual phase latches low then high.
// R20: Word address converted to byte address.
// R21: Strobes synchronised, one access per cycle.
// R22: Straps sampled after reset, then held.
`include "hpbi_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module hpbi_host_port (
    input  wire        REF_CLK,
    input  wire        ARST_N,
    input  wire        CLK_EN,
    input  wire        CFG_MUX_MODE,
    input  wire        CFG_DIRECT_MAP,
    input  wire        CFG_WIDTH16,
    input  wire        CFG_DUAL_PHASE,
    input  wire        CFG_CTRL_STYLE,
    input  wire        CFG_CS_QUAL,
    input  wire        CFG_CS_POL,
    input  wire        CFG_RD_POL,
    input  wire        CFG_WR_POL,
    input  wire        CFG_LANE_POL,
    input  wire        CFG_LATCH_POL,
    input  wire        CFG_WAIT_POL,
    input  wire        CFG_WAIT_OD,
    input  wire        CFG_WAIT_EN,
    input  wire        CFG_BIG_ENDIAN,
    input  wire        CS,
    input  wire        RD_DIR,
    input  wire        WR_CYCLE,
    input  wire        LANE0_SELECT,
    input  wire        LANE1_SELECT,
    input  wire        LATCH_STROBE_LOW,
    input  wire        LATCH_STROBE_HIGH,
    input  wire [15:0] AD_IN,
    output reg  [15:0] AD_OUT,
    output reg  [15:0] AD_OE,
    input  wire [4:0]  ADDR_IN,
    output reg         WAIT_OUT,
    output reg         WAIT_OE,
    output reg         INT_REQ,
    output reg         INT_WRITE,
    output reg  [15:0] INT_ADDR,
    output reg  [31:0] INT_WDATA,
    output reg  [3:0]  INT_BE,
    output reg         INT_FIFO,
    input  wire [31:0] INT_RDATA,
    input  wire        INT_DONE
);

    function act;
        input v;
        input pol;
        begin
            act = pol ? v : ~v;
        end
    endfunction

    function [15:0] low_mask;
        input [3:0] n;
        integer i;
        begin
            low_mask = 16'h0000;
            for (i = 0; i < 16; i = i + 1)
                low_mask[i] = (i < n);
        end
    endfunction

    function [31:0] swap32;
        input [31:0] d;
        begin
            swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
        end
    endfunction

    wire [`HPBI_SYNC_W-1:0] s;
    wire [`HPBI_SYNC_W-1:0] raw;

    assign raw = {CFG_BIG_ENDIAN, CFG_WAIT_EN, CFG_WAIT_OD, CFG_WAIT_POL,
                  CFG_LATCH_POL, CFG_LANE_POL, CFG_WR_POL, CFG_RD_POL,
                  CFG_CS_POL, CFG_CS_QUAL, CFG_CTRL_STYLE, CFG_DUAL_PHASE,
                  CFG_WIDTH16, CFG_DIRECT_MAP, CFG_MUX_MODE, ADDR_IN, AD_IN,
                  LATCH_STROBE_HIGH, LATCH_STROBE_LOW, LANE1_SELECT,
                  LANE0_SELECT, WR_CYCLE, RD_DIR, CS};

    // Data pins ride the same two stages as the strobes so both stay aligned.
    hpbi_sync #(
        .W (`HPBI_SYNC_W)
    ) u_sync (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .ce     (CLK_EN),
        .d      (raw),
        .q      (s)
    ); // R21

    wire [6:0]  sp = s[`HPBI_STRB_LSB +: 7];
    wire [15:0] ad = s[`HPBI_AD_LSB +: 16];
    wire [4:0]  ix = s[`HPBI_IX_LSB +: 5];

    reg  [`HPBI_CFG_W-1:0] cfg;
    reg                    cfg_ok;
    reg  [1:0]             cfg_cnt;

    wire mux   = cfg[`HPBI_C_MUX];
    wire dmap  = cfg[`HPBI_C_DMAP];
    wire w16   = cfg[`HPBI_C_W16];
    wire run   = CLK_EN & cfg_ok;

    // Decoded active levels of the host pins.
    reg cs_a;
    reg rd_a;
    reg wr_a;
    reg l0_a;
    reg l1_a;
    reg lo_a;
    reg hi_a;

    always @* begin
        cs_a = act(sp[0], cfg[`HPBI_C_CSPOL]); // R5
        if (cfg[`HPBI_C_STYLE]) begin
            rd_a = act(sp[2], cfg[`HPBI_C_WRPOL]) &
                   act(sp[1], cfg[`HPBI_C_RDPOL]); // R4
            wr_a = act(sp[2], cfg[`HPBI_C_WRPOL]) &
                   ~act(sp[1], cfg[`HPBI_C_RDPOL]); // R4
        end else begin
            rd_a = act(sp[1], cfg[`HPBI_C_RDPOL]); // R4
            wr_a = act(sp[2], cfg[`HPBI_C_WRPOL]); // R4
        end
        l0_a = act(sp[3], cfg[`HPBI_C_LNPOL]); // R12
        l1_a = act(sp[4], cfg[`HPBI_C_LNPOL]); // R12
        lo_a = mux & act(sp[5], cfg[`HPBI_C_LEPOL]); // R5
        hi_a = mux & act(sp[6], cfg[`HPBI_C_LEPOL]); // R5
    end

    wire rd_on = cs_a & rd_a;
    wire wr_on = cs_a & wr_a;

    reg rd_q;
    reg wr_q;
    reg lo_q;
    reg hi_q;
    reg lo_cs;
    reg hi_cs;

    wire rd_rise = rd_on & ~rd_q; // R21
    wire rd_fall = ~rd_on & rd_q;
    wire wr_fall = ~wr_on & wr_q;
    wire lo_fall = ~lo_a & lo_q;
    wire hi_fall = ~hi_a & hi_q;
    wire qual    = cfg[`HPBI_C_QUAL];
    wire lo_take = lo_fall & (~qual | lo_cs); // R6
    wire hi_take = hi_fall & (~qual | hi_cs); // R6

    // Latched pin image; its decoding depends on width and map mode.
    reg  [15:0] lat;
    reg  [1:0]  k;
    reg  [3:0]  abits;
    reg  [3:0]  n;
    reg  [3:0]  n1;
    reg  [15:0] cur_addr;
    reg         cur_big;
    reg         cur_fifo;
    reg         core;
    reg  [1:0]  pos;
    reg         last;

    always @* begin
        abits = dmap ? `HPBI_DM_ABITS : `HPBI_LEG_ABITS;
        n     = w16 ? abits - 4'd1 : abits;
        n1    = n + 4'd1;
        if (mux) begin // R1
            cur_addr = w16 ? ({lat[14:0], 1'b0} & low_mask(abits))
                           : (lat & low_mask(abits)); // R20
            cur_big  = lat[n]; // R18
            cur_fifo = ~dmap & lat[n1]; // R17
        end else begin
            cur_addr = w16 ? {11'h000, ix[4:1], 1'b0} : {11'h000, ix};
            cur_big  = cfg[`HPBI_C_BIGE]; // R18
            cur_fifo = ~dmap & (ix[4:2] == `HPBI_IDX_FIFO);
        end
        core = dmap & (cur_addr < `HPBI_SYS_BASE); // R3
        if (core)
            pos = cur_addr[1:0];
        else if (mux)
            pos = w16 ? {k[0], 1'b0} : k; // R2
        else
            pos = cur_addr[1:0];
        last = w16 ? pos[1] : (pos == 2'h3); // R2
    end

    // Write assembly.
    reg  [15:0] wd_q;
    reg  [1:0]  ln_q;
    reg  [31:0] wbuf;
    reg  [3:0]  wbe;
    reg  [15:0] wdat;
    reg  [1:0]  m2;
    reg  [3:0]  mask;
    reg  [31:0] next_wbuf;
    reg  [3:0]  next_wbe;
    integer     i;

    always @* begin
        wdat = (core & w16 & cur_big) ? {wd_q[7:0], wd_q[15:8]} : wd_q;
        if (!w16)
            m2 = 2'b01;
        else if (core)
            m2 = cur_big ? {ln_q[0], ln_q[1]} : ln_q; // R3
        else
            m2 = 2'b11;
        mask = {2'b00, m2} << pos;
        next_wbe = core ? mask : (wbe | mask); // R2
        for (i = 0; i < 4; i = i + 1) begin
            if (mask[i])
                next_wbuf[i*8 +: 8] = (w16 & i[0]) ? wdat[15:8] : wdat[7:0];
            else
                next_wbuf[i*8 +: 8] = core ? 8'h00 : wbuf[i*8 +: 8];
        end
    end

    // Read data selection from the held dword.
    reg  [31:0] rbuf;
    reg  [15:0] rsel;

    always @* begin
        rsel = {rbuf[{pos[1], 1'b1, 3'b000} +: 8], rbuf[{pos, 3'b000} +: 8]};
        if (!w16)
            rsel = {8'h00, rbuf[{pos, 3'b000} +: 8]};
        else if (core & cur_big)
            rsel = {rsel[7:0], rsel[15:8]}; // R18
    end

    // One queued internal access; the host must not stack a second.
    reg         pend_v;
    reg         pend_wr;
    reg  [15:0] pend_addr;
    reg  [31:0] pend_data;
    reg  [3:0]  pend_be;
    reg         pend_fifo;
    reg         busy;
    reg         busy_rd;
    reg         busy_big;
    reg         busy_core;

    wire need_rd = rd_rise & (core | pos == 2'h0); // R2
    wire do_wr   = wr_fall & (core | last);
    wire issue   = pend_v & ~busy; // R7
    wire wait_now = dmap & (rd_on | wr_on) &
                    (pend_v | busy | need_rd); // R8 R9

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg     <= {`HPBI_CFG_W{1'b0}};
            cfg_ok  <= 1'b0;
            cfg_cnt <= 2'h0;
        end else if (CLK_EN && !cfg_ok) begin
            cfg_cnt <= cfg_cnt + 2'h1;
            if (cfg_cnt == `HPBI_CFG_WAIT) begin
                cfg    <= s[`HPBI_CFG_LSB +: `HPBI_CFG_W]; // R22
                cfg_ok <= 1'b1; // R22
            end
        end
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            lo_q  <= 1'b0;
            hi_q  <= 1'b0;
            lo_cs <= 1'b0;
            hi_cs <= 1'b0;
            lat   <= `HPBI_RST_HALF;
            k     <= 2'h0;
            wd_q  <= `HPBI_RST_HALF;
            ln_q  <= 2'b00;
        end else if (run) begin
            rd_q  <= rd_on;
            wr_q  <= wr_on;
            lo_q  <= lo_a;
            hi_q  <= hi_a;
            lo_cs <= lo_a & (lo_cs | cs_a); // R6
            hi_cs <= hi_a & (hi_cs | cs_a); // R6
            if (wr_on) begin
                wd_q <= ad;
                ln_q <= {l1_a, l0_a}; // R12
            end
            // The address only changes on a latch strobe. R16
            if (lo_take && !cfg[`HPBI_C_DUAL])
                lat <= ad; // R13 R14
            else if (lo_take)
                lat[7:0] <= ad[7:0]; // R19
            if (hi_take && cfg[`HPBI_C_DUAL])
                lat[15:8] <= ad[7:0]; // R19
            if (lo_take | hi_take)
                k <= 2'h0;
            else if ((rd_fall | wr_fall) & mux & ~core)
                k <= last ? 2'h0 : k + 2'h1; // R2
        end
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wbuf      <= `HPBI_RST_WORD;
            wbe       <= 4'h0;
            pend_v    <= 1'b0;
            pend_wr   <= 1'b0;
            pend_addr <= `HPBI_RST_HALF;
            pend_data <= `HPBI_RST_WORD;
            pend_be   <= 4'h0;
            pend_fifo <= 1'b0;
        end else if (run) begin
            if (wr_fall) begin
                wbuf <= next_wbuf;
                wbe  <= do_wr ? 4'h0 : next_wbe;
            end
            if (issue)
                pend_v <= 1'b0;
            if (do_wr | need_rd) begin
                pend_v    <= 1'b1; // R21
                pend_wr   <= do_wr;
                pend_addr <= {cur_addr[15:2], 2'b00};
                pend_data <= (core | ~cur_big) ? next_wbuf
                                               : swap32(next_wbuf); // R18
                pend_be   <= core ? next_wbe : 4'hf; // R3
                pend_fifo <= cur_fifo; // R17
            end
        end
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            INT_REQ   <= 1'b0;
            INT_WRITE <= 1'b0;
            INT_ADDR  <= `HPBI_RST_HALF;
            INT_WDATA <= `HPBI_RST_WORD;
            INT_BE    <= 4'h0;
            INT_FIFO  <= 1'b0;
            busy      <= 1'b0;
            busy_rd   <= 1'b0;
            busy_big  <= 1'b0;
            busy_core <= 1'b0;
            rbuf      <= `HPBI_RST_WORD;
        end else if (run) begin
            INT_REQ <= issue;
            if (INT_DONE) begin
                busy <= 1'b0;
                if (busy_rd)
                    rbuf <= (busy_core | ~busy_big) ? INT_RDATA
                                                    : swap32(INT_RDATA);
            end
            if (issue) begin
                busy      <= 1'b1; // R7
                busy_rd   <= ~pend_wr;
                busy_big  <= cur_big;
                busy_core <= core;
                INT_WRITE <= pend_wr;
                INT_ADDR  <= pend_addr;
                INT_WDATA <= pend_data;
                INT_BE    <= pend_be;
                INT_FIFO  <= pend_fifo; // R17
            end
        end
    end

    // Open drain only ever pulls low, so the wired line needs a pull-up.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AD_OUT   <= `HPBI_RST_HALF;
            AD_OE    <= 16'h0000;
            WAIT_OUT <= 1'b0;
            WAIT_OE  <= 1'b0; // R11
        end else if (run) begin
            AD_OUT <= rsel;
            AD_OE  <= rd_on ? (w16 ? 16'hffff : 16'h00ff) : 16'h0000; // R15
            if (cfg[`HPBI_C_WTOD]) begin
                WAIT_OUT <= 1'b0; // R10
                WAIT_OE  <= cfg[`HPBI_C_WTEN] & wait_now; // R10 R11
            end else begin
                WAIT_OUT <= act(wait_now, cfg[`HPBI_C_WTPOL]); // R5 R9
                WAIT_OE  <= cfg[`HPBI_C_WTEN] & cs_a; // R10 R11
            end
        end
    end

endmodule // hpbi_host_port

`default_nettype wire

// ===== testbench/hpbi_host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none

module hpbi_host_port_sva (
    input wire logic        REF_CLK,
    input wire logic        ARST_N,
    input wire logic        CFG_MUX_MODE,
    input wire logic        CFG_DIRECT_MAP,
    input wire logic        CFG_WIDTH16,
    input wire logic        CFG_CTRL_STYLE,
    input wire logic        CFG_CS_POL,
    input wire logic        CFG_WR_POL,
    input wire logic        CFG_WAIT_POL,
    input wire logic        CFG_WAIT_OD,
    input wire logic        CS,
    input wire logic        WR_CYCLE,
    input wire logic [15:0] AD_OE,
    input wire logic        WAIT_OUT,
    input wire logic        WAIT_OE,
    input wire logic        INT_REQ,
    input wire logic        INT_WRITE,
    input wire logic [15:0] INT_ADDR
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    wire cs_on = (CS == CFG_CS_POL);
    wire wr_on = !CFG_CTRL_STYLE && cs_on && (WR_CYCLE == CFG_WR_POL);

    a_req_one_cycle: assert property (INT_REQ |=> !INT_REQ)
        else $error("internal request longer than one cycle");
    a_write_issued: assert property (CFG_DIRECT_MAP && wr_on ##1 !wr_on
        |-> ##[1:8] (INT_REQ && INT_WRITE))
        else $error("host write produced no internal write");
    a_addr_held: assert property (!INT_REQ |-> $stable(INT_ADDR))
        else $error("internal address moved without a request");
    a_wait_on_read: assert property (CFG_DIRECT_MAP && INT_REQ && !INT_WRITE
        && WAIT_OE && !CFG_WAIT_OD |-> WAIT_OUT == CFG_WAIT_POL)
        else $error("wait not shown while read data pending");
    a_ack_legacy: assert property (!CFG_DIRECT_MAP && WAIT_OE && !CFG_WAIT_OD
        |-> WAIT_OUT != CFG_WAIT_POL)
        else $error("wait shown outside direct mode");
    a_od_low_only: assert property (CFG_WAIT_OD && WAIT_OE |-> !WAIT_OUT)
        else $error("open drain wait drove high");
    a_upper_free: assert property (CFG_MUX_MODE && !CFG_WIDTH16
        |-> AD_OE[15:8] == 8'h00)
        else $error("upper address pins driven in 8-bit mode");
    a_idle_no_drive: assert property (!cs_on [*6]
        |-> AD_OE == 16'h0000 && !(WAIT_OE && !CFG_WAIT_OD))
        else $error("pins driven while not selected");
    a_reset_quiet: assert property ($rose(ARST_N)
        |-> AD_OE == 16'h0000 && !WAIT_OE && !INT_REQ)
        else $error("outputs active right after reset");

    c_write: cover property (INT_REQ && INT_WRITE);
    c_read: cover property (INT_REQ && !INT_WRITE);
    c_ack: cover property (WAIT_OE && WAIT_OUT != CFG_WAIT_POL);
endmodule // hpbi_host_port_sva

bind hpbi_host_port hpbi_host_port_sva u_sva (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CFG_MUX_MODE(CFG_MUX_MODE),
    .CFG_DIRECT_MAP(CFG_DIRECT_MAP), .CFG_WIDTH16(CFG_WIDTH16),
    .CFG_CTRL_STYLE(CFG_CTRL_STYLE), .CFG_CS_POL(CFG_CS_POL),
    .CFG_WR_POL(CFG_WR_POL), .CFG_WAIT_POL(CFG_WAIT_POL),
    .CFG_WAIT_OD(CFG_WAIT_OD), .CS(CS), .WR_CYCLE(WR_CYCLE), .AD_OE(AD_OE),
    .WAIT_OUT(WAIT_OUT), .WAIT_OE(WAIT_OE), .INT_REQ(INT_REQ),
    .INT_WRITE(INT_WRITE), .INT_ADDR(INT_ADDR));
`default_nettype wire

// ===== testbench/hpbi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module hpbi_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] ad_out,
    input  wire logic        wait_out,
    input  wire logic        wait_oe,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic             lane0_n,
    output logic             lane1_n,
    output logic             ale,
    output logic [15:0]      ad_drv
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        lane0_n = 1'b0;
        lane1_n = 1'b0;
        ale = 1'b0;
        ad_drv = 16'h0000;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Chip select may be withheld to probe latch qualification.
    task automatic latch(input logic [15:0] a, input logic with_cs);
        ad_drv = a;
        cs_n = !with_cs;
        ale = 1'b1;
        step(4);
        ale = 1'b0;
        step(4);
        cs_n = 1'b1;
        ad_drv = ~a;
        step(4);
    endtask

    // Worst-case spacing is used instead of the wait pin for writes.
    task automatic wr(input logic [15:0] d, input logic [1:0] lanes_n);
        ad_drv = d;
        lane0_n = lanes_n[0];
        lane1_n = lanes_n[1];
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(5);
        wr_n = 1'b1;
        cs_n = 1'b1;
        step(1);
        ad_drv = ~d;
        step(14);
    endtask

    task automatic rd(output logic [15:0] d);
        int i;
        cs_n = 1'b0;
        rd_n = 1'b0;
        step(6);
        for (i = 0; i < 40 && !(wait_oe && wait_out); i++) step(1);
        d = ad_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        step(6);
    endtask

    task automatic cs_set(input logic v);
        cs_n = v;
        step(6);
    endtask
endmodule // hpbi_host_model
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk, arst_n, cs_n, rd_n, wr_n, lane0_n, lane1_n, ale;
    logic [14:0] cfg;
    logic [15:0] ad_drv, ad_out, ad_oe, int_addr, req_addr, d;
    wire  [15:0] ad_in = (ad_oe & ad_out) | (~ad_oe & ad_drv);
    logic        wait_out, wait_oe, int_req, int_write, int_fifo, int_done;
    logic        req_we;
    logic [31:0] int_wdata, int_rdata, req_wd;
    logic [3:0]  int_be, req_be;
    logic [2:0]  dly;
    int          req_cnt, errors, total_checks;

    hpbi_host_port u_dut (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .CLK_EN(1'b1),
        .CFG_MUX_MODE(cfg[0]), .CFG_DIRECT_MAP(cfg[1]), .CFG_WIDTH16(cfg[2]),
        .CFG_DUAL_PHASE(cfg[3]), .CFG_CTRL_STYLE(cfg[4]),
        .CFG_CS_QUAL(cfg[5]), .CFG_CS_POL(cfg[6]), .CFG_RD_POL(cfg[7]),
        .CFG_WR_POL(cfg[8]), .CFG_LANE_POL(cfg[9]), .CFG_LATCH_POL(cfg[10]),
        .CFG_WAIT_POL(cfg[11]), .CFG_WAIT_OD(cfg[12]), .CFG_WAIT_EN(cfg[13]),
        .CFG_BIG_ENDIAN(cfg[14]), .CS(cs_n), .RD_DIR(rd_n), .WR_CYCLE(wr_n),
        .LANE0_SELECT(lane0_n), .LANE1_SELECT(lane1_n),
        .LATCH_STROBE_LOW(ale), .LATCH_STROBE_HIGH(1'b0), .AD_IN(ad_in),
        .AD_OUT(ad_out), .AD_OE(ad_oe), .ADDR_IN(5'h00),
        .WAIT_OUT(wait_out), .WAIT_OE(wait_oe), .INT_REQ(int_req),
        .INT_WRITE(int_write), .INT_ADDR(int_addr), .INT_WDATA(int_wdata),
        .INT_BE(int_be), .INT_FIFO(int_fifo), .INT_RDATA(int_rdata),
        .INT_DONE(int_done));

    hpbi_host_model u_host (
        .clk(ref_clk), .ad_out(ad_out), .wait_out(wait_out),
        .wait_oe(wait_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .lane0_n(lane0_n), .lane1_n(lane1_n), .ale(ale), .ad_drv(ad_drv));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Internal side answers every request a few cycles later.
    always @(posedge ref_clk) begin
        #1;
        int_done = (dly == 3'h1);
        if (int_req === 1'b1) begin
            dly = 3'h6;
            req_cnt++;
            req_we = int_write;
            req_addr = int_addr;
            req_wd = int_wdata;
            req_be = int_be;
        end else if (dly != 3'h0) begin
            dly = dly - 3'h1;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Straps change only under reset, since they are captured after it.
    task automatic do_reset(input logic [14:0] c);
        arst_n = 1'b0;
        cfg = c;
        repeat (12) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_reset;
        chk("ad_oe", 32'h0, {16'h0, ad_oe});
        chk("wait_oe", 32'h0, {31'h0, wait_oe});
        $display("t_reset done");
    endtask

    task automatic t_write;
        int c0 = req_cnt;
        u_host.latch(16'h0081, 1'b1);
        u_host.wr(16'ha55a, 2'b00);
        chk("count", c0 + 1, req_cnt);
        chk("we", 32'h1, {31'h0, req_we});
        chk("addr", 32'h0100, {16'h0, req_addr});
        chk("be", 32'hc, {28'h0, req_be});
        chk("wdata", 32'ha55a, {16'h0, req_wd[31:16]});
        $display("t_write done");
    endtask

    task automatic t_repeat;
        u_host.wr(16'h0f0f, 2'b10);
        chk("addr", 32'h0100, {16'h0, req_addr});
        chk("be", 32'h4, {28'h0, req_be});
        $display("t_repeat done");
    endtask

    task automatic t_read;
        int c0 = req_cnt;
        u_host.latch(16'h0080, 1'b1);
        u_host.rd(d);
        chk("rdata", 32'h2468, {16'h0, d});
        chk("count", c0 + 1, req_cnt);
        chk("we", 32'h0, {31'h0, req_we});
        chk("addr", 32'h0100, {16'h0, req_addr});
        $display("t_read done");
    endtask

    task automatic t_endian;
        u_host.latch(16'h2080, 1'b1);
        u_host.wr(16'h1234, 2'b00);
        chk("wdata", 32'h3412, {16'h0, req_wd[15:0]});
        chk("be", 32'h3, {28'h0, req_be});
        $display("t_endian done");
    endtask

    task automatic t_qual;
        u_host.latch(16'h0100, 1'b0);
        u_host.wr(16'h00ff, 2'b00);
        chk("addr", 32'h0100, {16'h0, req_addr});
        $display("t_qual done");
    endtask

    task automatic t_legacy;
        int c0;
        do_reset(15'h2425);
        u_host.cs_set(1'b0);
        chk("wait_oe", 32'h1, {31'h0, wait_oe});
        chk("wait_out", 32'h1, {31'h0, wait_out});
        u_host.cs_set(1'b1);
        // Two words pair into one dword write at the last word.
        c0 = req_cnt;
        u_host.latch(16'h0410, 1'b1);
        u_host.wr(16'h1111, 2'b00);
        u_host.wr(16'h2222, 2'b00);
        chk("count", c0 + 1, req_cnt);
        chk("addr", 32'h0020, {16'h0, req_addr});
        chk("be", 32'hf, {28'h0, req_be});
        chk("wdata", 32'h22221111, req_wd);
        chk("fifo", 32'h1, {31'h0, int_fifo});
        $display("t_legacy done");
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("watchdog expired");
        tally_and_finish;
    end

    initial begin
        int_rdata = 32'h1357_2468;
        int_done = 1'b0;
        dly = 3'h0;
        req_cnt = 0;
        errors = 0;
        total_checks = 0;
        // Mux, direct, 16-bit, single phase, qualified, wait push-pull.
        do_reset(15'h2427);
        t_reset;
        t_write;
        t_repeat;
        t_read;
        t_endian;
        t_qual;
        t_legacy;
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
